// File: design/ssge_defs.svh
// Offsets, fields, reset values, the ramp step and response codes for the spindle block
`ifndef SSGE_DEFS_SVH
`define SSGE_DEFS_SVH
`define SSGE_OFS_CTRL 8'h00
`define SSGE_OFS_LEAD_REV 8'h04
`define SSGE_OFS_SYNC_REV 8'h08
`define SSGE_OFS_ANGLE 8'h0c
`define SSGE_OFS_AVG_SPEED 8'h10
`define SSGE_OFS_DITH_AMP 8'h14
`define SSGE_OFS_DITH_PER 8'h18
`define SSGE_OFS_VEL_WIN 8'h1c
`define SSGE_OFS_POS_WIN 8'h20
`define SSGE_OFS_STATUS 8'h24
`define SSGE_OFS_IRQ_STAT 8'h28
`define SSGE_OFS_IRQ_CLR 8'h2c
`define SSGE_OFS_IRQ_EN 8'h30
`define SSGE_OFS_CORR_SPEED 8'h34
`define SSGE_CTRL_SYNC_ON 0
`define SSGE_CTRL_ANGLE_MODE 1
`define SSGE_CTRL_RATIO_APPLY 2
`define SSGE_CTRL_GEAR_CMD 3
`define SSGE_ST_SYNC 0
`define SSGE_ST_EXEC 1
`define SSGE_ST_CHANGE 2
`define SSGE_ST_OFS_BUSY 3
`define SSGE_ST_GEAR_ACT 4
`define SSGE_EV_SYNC 0
`define SSGE_EV_EXEC 1
`define SSGE_EV_ANGLE 2
`define SSGE_RST_CTRL 32'h0000_0004
`define SSGE_RST_REV 32'h0000_0001
`define SSGE_RST_DITH_PER 32'h0000_0064
`define SSGE_RST_CORR 32'h0000_0010
`define SSGE_RAMP_STEP 32'h0000_0001
`define SSGE_AXI_OKAY 2'b00
`define SSGE_AXI_SLVERR 2'b10
`endif

// File: design/ssge_pkg.sv
// Types shared by the spindle sync and gear engage block
package ssge_pkg;
	typedef struct packed {
		logic signed [31:0] cmd_speed;
		logic signed [31:0] lead_speed;
		logic signed [31:0] fb_speed;
		logic signed [31:0] fb_pos;
	} ssge_fb_type;
	typedef struct packed {
		logic signed [31:0] speed_ref;
		logic ignore_cmd;
	} ssge_drv_type;
	typedef enum logic [1:0] {
		SSGE_G_IDLE,
		SSGE_G_RAMP,
		SSGE_G_SETTLE,
		SSGE_G_EXEC
	} ssge_gear_type;
endpackage

// File: design/ssge_top.sv
// Spindle synchronous update and gear engage logic with AXI4-Lite registers
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "ssge_defs.svh"
module ssge_top
	import ssge_pkg::*;
#(
	parameter int DW = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input ssge_fb_type fb,
	output ssge_drv_type drv,
	output logic irq
);
	if (DW != 32)
		$error("ssge_top supports DW = 32 only");
	function automatic logic [31:0] abs_diff(input logic signed [31:0] a,
		input logic signed [31:0] b);
		logic signed [31:0] d;
		d = a - b;
		abs_diff = d[31] ? 32'(-d) : 32'(d);
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				m[i*8 +: 8] = nw[i*8 +: 8];
		end
		merge = m;
	endfunction
	logic [7:0] aw_addr_r;
	logic aw_full_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic w_full_r;
	logic wr_go;
	logic wr_ok;
	logic [31:0] ctrl_r;
	logic [31:0] lead_rev_r;
	logic [31:0] sync_rev_r;
	logic signed [31:0] angle_r;
	logic signed [31:0] avg_speed_r;
	logic [31:0] dith_amp_r;
	logic [31:0] dith_per_r;
	logic [31:0] vel_win_r;
	logic [31:0] pos_win_r;
	logic [31:0] corr_r;
	logic [31:0] irq_en_r;
	logic [2:0] irq_stat_r;
	logic [2:0] irq_ev;
	logic [2:0] irq_clr;
	logic angle_wr;
	logic [31:0] app_lead_r;
	logic [31:0] app_sync_r;
	logic signed [31:0] sync_target;
	logic signed [31:0] run_target;
	logic signed [31:0] ref_r;
	logic ofs_busy_r;
	logic sync_r;
	logic ref_at_target;
	ssge_gear_type gear_r;
	logic [31:0] dith_cnt_r;
	logic dith_wrap;
	logic settle_done_r;
	assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
	assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
	assign s_axi_wready = !w_full_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	// Address and data taken in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_full_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_full_r <= 1'b0;
			end
		end
	end
	always_comb begin
		unique case ({aw_addr_r[7:2], 2'b00})
			`SSGE_OFS_CTRL, `SSGE_OFS_LEAD_REV, `SSGE_OFS_SYNC_REV,
			`SSGE_OFS_ANGLE, `SSGE_OFS_AVG_SPEED, `SSGE_OFS_DITH_AMP,
			`SSGE_OFS_DITH_PER, `SSGE_OFS_VEL_WIN, `SSGE_OFS_POS_WIN,
			`SSGE_OFS_IRQ_CLR, `SSGE_OFS_IRQ_EN,
			`SSGE_OFS_CORR_SPEED: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SSGE_AXI_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `SSGE_AXI_OKAY : `SSGE_AXI_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign angle_wr = wr_go && aw_addr_r[7:2] == `SSGE_OFS_ANGLE >> 2;
	// Register file written from the bus
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `SSGE_RST_CTRL;
			lead_rev_r <= `SSGE_RST_REV;
			sync_rev_r <= `SSGE_RST_REV;
			angle_r <= 32'h0000_0000;
			avg_speed_r <= 32'h0000_0000;
			dith_amp_r <= 32'h0000_0000;
			dith_per_r <= `SSGE_RST_DITH_PER;
			vel_win_r <= 32'h0000_0000;
			pos_win_r <= 32'h0000_0000;
			corr_r <= `SSGE_RST_CORR;
			irq_en_r <= 32'h0000_0000;
		end else if (ce && wr_go) begin
			unique case ({aw_addr_r[7:2], 2'b00})
				`SSGE_OFS_CTRL: ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) &
					32'h0000_000f;
				`SSGE_OFS_LEAD_REV: lead_rev_r <= merge(lead_rev_r, w_data_r,
					w_strb_r);
				`SSGE_OFS_SYNC_REV: sync_rev_r <= merge(sync_rev_r, w_data_r,
					w_strb_r);
				`SSGE_OFS_ANGLE: angle_r <= merge(angle_r, w_data_r, w_strb_r);
				`SSGE_OFS_AVG_SPEED: avg_speed_r <= merge(avg_speed_r,
					w_data_r, w_strb_r);
				`SSGE_OFS_DITH_AMP: dith_amp_r <= merge(dith_amp_r, w_data_r,
					w_strb_r);
				`SSGE_OFS_DITH_PER: dith_per_r <= merge(dith_per_r, w_data_r,
					w_strb_r);
				`SSGE_OFS_VEL_WIN: vel_win_r <= merge(vel_win_r, w_data_r,
					w_strb_r);
				`SSGE_OFS_POS_WIN: pos_win_r <= merge(pos_win_r, w_data_r,
					w_strb_r);
				`SSGE_OFS_CORR_SPEED: corr_r <= merge(corr_r, w_data_r,
					w_strb_r);
				`SSGE_OFS_IRQ_EN: irq_en_r <= merge(irq_en_r, w_data_r,
					w_strb_r) & 32'h0000_0007;
				default: ;
			endcase
		end
	end
	assign irq_clr = (wr_go && aw_addr_r[7:2] == `SSGE_OFS_IRQ_CLR >> 2) ?
		w_data_r[2:0] : 3'b000;
	// Read channel, answer one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SSGE_AXI_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `SSGE_AXI_OKAY;
				unique case ({s_axi_araddr[7:2], 2'b00})
					`SSGE_OFS_CTRL: s_axi_rdata <= ctrl_r;
					`SSGE_OFS_LEAD_REV: s_axi_rdata <= lead_rev_r;
					`SSGE_OFS_SYNC_REV: s_axi_rdata <= sync_rev_r;
					`SSGE_OFS_ANGLE: s_axi_rdata <= angle_r;
					`SSGE_OFS_AVG_SPEED: s_axi_rdata <= avg_speed_r;
					`SSGE_OFS_DITH_AMP: s_axi_rdata <= dith_amp_r;
					`SSGE_OFS_DITH_PER: s_axi_rdata <= dith_per_r;
					`SSGE_OFS_VEL_WIN: s_axi_rdata <= vel_win_r;
					`SSGE_OFS_POS_WIN: s_axi_rdata <= pos_win_r;
					`SSGE_OFS_CORR_SPEED: s_axi_rdata <= corr_r;
					`SSGE_OFS_IRQ_EN: s_axi_rdata <= irq_en_r;
					`SSGE_OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_r};
					`SSGE_OFS_STATUS: s_axi_rdata <= {27'h0,
						gear_r != SSGE_G_IDLE, ofs_busy_r,
						gear_r == SSGE_G_EXEC, gear_r == SSGE_G_EXEC, sync_r};
					`SSGE_OFS_IRQ_CLR: s_axi_rdata <= 32'h0000_0000;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `SSGE_AXI_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// New revolutions only take hold while apply is high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			app_lead_r <= `SSGE_RST_REV;
			app_sync_r <= `SSGE_RST_REV;
		end else if (ce && ctrl_r[`SSGE_CTRL_RATIO_APPLY]) begin
			app_lead_r <= lead_rev_r;
			app_sync_r <= sync_rev_r;
		end
	end
	// Zero lead revs would divide by zero; hold the lead speed instead
	always_comb begin
		logic signed [63:0] prod;
		prod = 64'(fb.lead_speed) * 64'(signed'({1'b0, app_sync_r[30:0]}));
		if (app_lead_r[30:0] == 31'h0000_0000)
			sync_target = fb.lead_speed;
		else
			sync_target = 32'(prod / 64'(signed'({1'b0, app_lead_r[30:0]})));
	end
	// Angle correction runs until the position sits inside its window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ofs_busy_r <= 1'b0;
		end else if (ce) begin
			if (angle_wr && ctrl_r[`SSGE_CTRL_SYNC_ON] &&
				ctrl_r[`SSGE_CTRL_ANGLE_MODE])
				ofs_busy_r <= 1'b1;
			else if (abs_diff(angle_r, fb.fb_pos) <= pos_win_r ||
				!ctrl_r[`SSGE_CTRL_SYNC_ON])
				ofs_busy_r <= 1'b0;
		end
	end

	always_comb begin
		logic signed [31:0] dith;
		dith = (dith_cnt_r < (dith_per_r >> 1)) ? signed'(dith_amp_r) :
			32'(-signed'(dith_amp_r));
		if (gear_r == SSGE_G_RAMP)
			run_target = avg_speed_r;
		else if (gear_r != SSGE_G_IDLE)
			run_target = 32'(avg_speed_r + dith);
		else if (!ctrl_r[`SSGE_CTRL_SYNC_ON])
			run_target = fb.cmd_speed;
		else if (ofs_busy_r)
			run_target = (angle_r - fb.fb_pos > 0) ?
				32'(sync_target + signed'(corr_r)) :
				32'(sync_target - signed'(corr_r));
		else
			run_target = sync_target;
	end

	assign ref_at_target = abs_diff(ref_r, run_target) <= `SSGE_RAMP_STEP;

	// In sync and gear modes the speed reference slews one step a cycle to avoid torque jumps; otherwise it takes the command directly
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_r <= 32'h0000_0000;
		end else if (ce) begin
			if (gear_r == SSGE_G_IDLE && !ctrl_r[`SSGE_CTRL_SYNC_ON])
				ref_r <= fb.cmd_speed;
			else if (ref_at_target)
				ref_r <= run_target;
			else if (run_target > ref_r)
				ref_r <= 32'(ref_r + `SSGE_RAMP_STEP);
			else
				ref_r <= 32'(ref_r - `SSGE_RAMP_STEP);
		end
	end

	assign drv.speed_ref = ref_r;
	assign drv.ignore_cmd = gear_r != SSGE_G_IDLE;

	assign dith_wrap = dith_cnt_r + 32'h0000_0001 >= dith_per_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dith_cnt_r <= 32'h0000_0000;
		end else if (ce) begin
			if (gear_r == SSGE_G_IDLE || gear_r == SSGE_G_RAMP || dith_wrap)
				dith_cnt_r <= 32'h0000_0000;
			else
				dith_cnt_r <= dith_cnt_r + 32'h0000_0001;
		end
	end

	// Gear engage sequence; executed needs average reached plus one period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gear_r <= SSGE_G_IDLE;
			settle_done_r <= 1'b0;
		end else if (ce) begin
			settle_done_r <= 1'b0;
			if (!ctrl_r[`SSGE_CTRL_GEAR_CMD]) begin
				gear_r <= SSGE_G_IDLE;
			end else begin
				unique case (gear_r)
					SSGE_G_IDLE: gear_r <= SSGE_G_RAMP;
					SSGE_G_RAMP:
						if (ref_at_target)
							gear_r <= SSGE_G_SETTLE;
					SSGE_G_SETTLE:
						if (dith_wrap) begin
							gear_r <= SSGE_G_EXEC;
							settle_done_r <= 1'b1;
						end
					SSGE_G_EXEC: gear_r <= SSGE_G_EXEC;
				endcase
			end
		end
	end

	// Sync flag from velocity or position window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_r <= 1'b0;
		end else if (ce) begin
			if (!ctrl_r[`SSGE_CTRL_SYNC_ON])
				sync_r <= 1'b0;
			else if (ctrl_r[`SSGE_CTRL_ANGLE_MODE])
				sync_r <= abs_diff(angle_r, fb.fb_pos) <= pos_win_r;
			else
				sync_r <= abs_diff(fb.fb_speed, sync_target) <= vel_win_r;
		end
	end

	logic sync_d_r;
	logic ofs_d_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_d_r <= 1'b0;
			ofs_d_r <= 1'b0;
		end else if (ce) begin
			sync_d_r <= sync_r;
			ofs_d_r <= ofs_busy_r;
		end
	end

	assign irq_ev[`SSGE_EV_SYNC] = sync_r && !sync_d_r;
	assign irq_ev[`SSGE_EV_EXEC] = settle_done_r;
	assign irq_ev[`SSGE_EV_ANGLE] = ofs_d_r && !ofs_busy_r;

	// Set beats clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_stat_r <= 3'b000;
		else if (ce)
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
	end

	assign irq = |(irq_stat_r & irq_en_r[2:0]);
endmodule

// File: verification/ssge_ctl_model.sv
// Control unit and spindle plant model feeding the block
`timescale 1ns/1ns
module ssge_ctl_model
	import ssge_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic signed [31:0] cmd,
	input wire logic signed [31:0] lead,
	input wire ssge_drv_type drv,
	output ssge_fb_type fb
);
	// Ideal speed loop, one cycle lag; position integrates speed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fb <= '0;
		end else begin
			fb.cmd_speed <= cmd;
			fb.lead_speed <= lead;
			fb.fb_speed <= drv.speed_ref;
			fb.fb_pos <= fb.fb_pos + fb.fb_speed;
		end
	end
endmodule

// File: verification/ssge_monitor.sv
// Port checker for the spindle sync and gear engage block
`timescale 1ns/1ns
module ssge_monitor
	import ssge_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire ssge_drv_type drv,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_wr_resp;
		s_wr_both |=> ##1 s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_rd_resp;
		s_rd_take |=> s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_w_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_refuse: assert property (p_w_refuse) else $error("write taken early");
	property p_r_refuse;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_r_refuse: assert property (p_r_refuse) else $error("read taken early");
	// Gear mode never jumps: one step per cycle
	property p_ramp;
		drv.ignore_cmd && $past(drv.ignore_cmd) |->
			(drv.speed_ref - $past(drv.speed_ref)) inside {-1, 0, 1};
	endproperty
	a_ramp: assert property (p_ramp) else $error("gear speed jumped");
	property p_rst;
		disable iff (1'b0) !aresetn && ce |=> drv.speed_ref == 0 &&
			!drv.ignore_cmd && !irq && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind ssge_top ssge_monitor i_ssge_monitor (.aclk, .aresetn, .ce,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .drv, .irq);

// File: verification/tb_spindle_sync_gear_engage.sv
// Register-level bench for the spindle sync and gear engage block
`timescale 1ns/1ns
`include "ssge_defs.svh"
module tb_spindle_sync_gear_engage;
	import ssge_pkg::*;
	logic aclk = 0, aresetn = 0, ce = 1, irq;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic signed [31:0] cmd = 0, lead = 0;
	ssge_fb_type fb;
	ssge_drv_type drv;
	int n_fail = 0, comparisons = 0, cyc = 0, hi = 0, lo = 0;
	always #10 aclk = ~aclk;
	ssge_top i_ssge_top (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fb, .drv, .irq);
	ssge_ctl_model i_ssge_ctl_model (.aclk, .aresetn, .cmd, .lead, .drv, .fb);
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
		chk({30'h0, got}, {30'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(v, exp);
	endtask
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(`SSGE_OFS_CTRL, `SSGE_RST_CTRL);
		rchk(`SSGE_OFS_LEAD_REV, `SSGE_RST_REV);
		rchk(`SSGE_OFS_SYNC_REV, `SSGE_RST_REV);
		rchk(`SSGE_OFS_DITH_PER, `SSGE_RST_DITH_PER);
		rchk(`SSGE_OFS_CORR_SPEED, `SSGE_RST_CORR);
		rchk(`SSGE_OFS_IRQ_CLR, 32'h0);
		rd(8'h40);
		chk_rsp(rsp, `SSGE_AXI_SLVERR);
		wr(8'h40, 32'h1);
		chk_rsp(rsp, `SSGE_AXI_SLVERR);
		wr(`SSGE_OFS_STATUS, 32'hff);
		chk_rsp(rsp, `SSGE_AXI_SLVERR);
		rchk(`SSGE_OFS_STATUS, 32'h0);
		s_axi_wstrb <= 4'h2;
		wr(`SSGE_OFS_VEL_WIN, 32'hffff_ffff);
		s_axi_wstrb <= 4'hf;
		rchk(`SSGE_OFS_VEL_WIN, 32'h0000_ff00);
		lead <= 32'sd10;
		wr(`SSGE_OFS_VEL_WIN, 32'h2);
		wr(`SSGE_OFS_SYNC_REV, 32'h2);
		wr(`SSGE_OFS_CTRL, 32'h5);
		repeat (40) @(posedge aclk);
		chk(drv.speed_ref, 32'h14);
		rd(`SSGE_OFS_STATUS);
		chk(v & 32'h1, 32'h1);
		wr(`SSGE_OFS_CTRL, 32'h1);
		wr(`SSGE_OFS_SYNC_REV, 32'h3);
		repeat (40) @(posedge aclk);
		chk(drv.speed_ref, 32'h14);
		wr(`SSGE_OFS_CTRL, 32'h5);
		repeat (40) @(posedge aclk);
		chk(drv.speed_ref, 32'h1e);
		wr(`SSGE_OFS_POS_WIN, 32'h40);
		wr(`SSGE_OFS_CTRL, 32'h7);
		wr(`SSGE_OFS_ANGLE, fb.fb_pos + 32'd2000);
		rd(`SSGE_OFS_STATUS);
		chk(v & 32'h8, 32'h8);
		chk(32'(drv.speed_ref > 32'sd30), 32'h1);
		repeat (150) @(posedge aclk);
		rd(`SSGE_OFS_STATUS);
		chk(v & 32'h8, 32'h0);
		chk(drv.speed_ref, 32'h1e);
		cmd <= 32'sd50;
		wr(`SSGE_OFS_CTRL, 32'h0);
		wr(`SSGE_OFS_AVG_SPEED, 32'h28);
		wr(`SSGE_OFS_DITH_AMP, 32'h3);
		wr(`SSGE_OFS_DITH_PER, 32'ha);
		wr(`SSGE_OFS_CTRL, 32'h8);
		@(posedge aclk);
		chk(32'(drv.ignore_cmd), 32'h1);
		v = 32'h0;
		for (int i = 0; i < 50 && v[1] !== 1'b1; i++)
			rd(`SSGE_OFS_STATUS);
		chk(v & 32'h16, 32'h16);
		repeat (40) begin
			@(posedge aclk);
			chk(32'(drv.speed_ref >= 37 && drv.speed_ref <= 43), 32'h1);
			hi += int'(drv.speed_ref > 40);
			lo += int'(drv.speed_ref < 40);
		end
		// Enable low must freeze the dithering reference
		ce <= 1'b0;
		@(posedge aclk);
		v = drv.speed_ref;
		repeat (10) @(posedge aclk);
		chk(drv.speed_ref, v);
		ce <= 1'b1;
		chk(32'(hi > 0 && lo > 0), 32'h1);
		cmd <= -32'sd5;
		wr(`SSGE_OFS_CTRL, 32'h0);
		repeat (4) @(posedge aclk);
		chk(drv.speed_ref, -32'sd5);
		chk(32'(drv.ignore_cmd), 32'h0);
		rchk(`SSGE_OFS_STATUS, 32'h0);
		wr(`SSGE_OFS_IRQ_EN, 32'h7);
		chk(32'(irq), 32'h1);
		rchk(`SSGE_OFS_IRQ_STAT, 32'h7);
		wr(`SSGE_OFS_IRQ_EN, 32'h0);
		chk(32'(irq), 32'h0);
		wr(`SSGE_OFS_IRQ_CLR, 32'h3);
		rchk(`SSGE_OFS_IRQ_STAT, 32'h4);
		conclude();
	end
endmodule
